// [verification/spc_ctrl_sva.sv]
/* Port assertions for the sector protection controller.
   Bound into spc_ctrl; op bit 0 marks reads, bit 1 unprotect and query. */
module spc_ctrl_sva (
	input wire logic clk,
	input wire logic rstn,
	input wire logic op_valid,
	input wire logic [1:0] op,
	input wire logic op_ready,
	input wire logic res_valid,
	input wire logic res_protected,
	input wire logic [7:0] res_data,
	input wire logic [17:0] addr,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic hv_addr_en,
	input wire logic hv_oe_en
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cur_op;
	logic wr_hv;
	logic rd_on;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cur_op <= 2'h0;
		end else if (op_valid && op_ready) begin
			cur_op <= op;
		end
	end
	assign wr_hv = !we_n && hv_oe_en;
	assign rd_on = !oe_n && !hv_oe_en;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_prot;
		wr_hv && !addr[6] |-> hv_addr_en && !ce_n && !cur_op[0];
	endproperty
	a_prot: assert property (p_prot) else $error("protect pins");
	property p_unprot;
		wr_hv && addr[6] |-> hv_addr_en && !ce_n && cur_op == 2'h2;
	endproperty
	a_unprot: assert property (p_unprot) else $error("unprotect pins");
	property p_pulse;
		$fell(we_n) && hv_oe_en |-> !we_n [*8] ##1 !we_n [*2];
	endproperty
	a_pulse: assert property (p_pulse) else $error("short pulse");
	property p_hold;
		$rose(we_n) && $past(hv_oe_en) |-> hv_oe_en && hv_addr_en;
	endproperty
	a_hold: assert property (p_hold) else $error("select dropped");
	property p_verify;
		rd_on && hv_addr_en |-> !ce_n && we_n && addr[1] && !addr[0]
			&& !addr[6];
	endproperty
	a_verify: assert property (p_verify) else $error("verify pins");
	property p_query;
		rd_on && !hv_addr_en |-> !ce_n && we_n && addr[1];
	endproperty
	a_query: assert property (p_query) else $error("query pins");
	property p_result;
		res_valid && cur_op[0] |-> res_data == {7'h0, res_protected};
	endproperty
	a_result: assert property (p_result) else $error("status byte");
	property p_flag;
		res_valid && !cur_op[0] |-> res_protected == !cur_op[1];
	endproperty
	a_flag: assert property (p_flag) else $error("write flag");
	c_prot: cover property (res_valid && cur_op == 2'h0);
	c_unprot: cover property (res_valid && cur_op == 2'h2);
	c_hit: cover property (res_valid && cur_op[0] && res_protected);
endmodule : spc_ctrl_sva

bind spc_ctrl spc_ctrl_sva i_sva (.clk, .rstn, .op_valid, .op, .op_ready,
	.res_valid, .res_protected, .res_data, .addr, .ce_n, .oe_n, .we_n,
	.hv_addr_en, .hv_oe_en);

// [verification/spc_flash_model.sv]
/* Behavioural flash seen through its protection pins.
   Host drives strobes, address and data one byte cycle at a time. */
module spc_flash_model #(
	parameter logic [7:0] ID_CODE = 8'h3c // Arbitrary identity value
) (
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic hv_addr,
	input wire logic hv_oe,
	input wire logic [17:0] addr,
	input wire logic [7:0] host_q,
	input wire logic host_oe_n,
	output logic [7:0] bus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] prot = '0;
	logic id_mode = 1'b0;
	logic [7:0] last = 8'h00;
	logic [7:0] rd;
	logic drive;
	always @(posedge we_n) begin
		if (!ce_n && hv_oe && hv_addr) begin
			if (addr[6]) prot <= '0;
			else prot[addr[17:12]] <= 1'b1;
		end else if (!ce_n) begin
			if (host_q == 8'h90 && addr[10:0] == 11'h555) id_mode <= 1'b1;
			if (host_q == 8'hf0) id_mode <= 1'b0;
		end
	end
	assign rd = addr[1] ? {7'h0, prot[addr[17:12]]} : ID_CODE;
	assign drive = !ce_n && !oe_n && !hv_oe && (hv_addr || id_mode);
	// Released bus shows the inverse of the last byte
	always @(*) if (drive) last = rd;
	assign bus = !host_oe_n ? host_q : drive ? rd : ~last;
endmodule : spc_flash_model

// [verification/tb.sv]
/* Self-checking bench for spc_ctrl with the flash model on its pins.
   Checker is bound in from its own file. */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, op_valid, op_ready, res_valid, res_protected;
	logic dq_oe_n, ce_n, oe_n, we_n, hv_addr_en, hv_oe_en;
	logic [1:0] op;
	logic [5:0] sector;
	logic [7:0] res_data, dq_in, dq_out;
	logic [17:0] addr;
	int errors = 0;
	int checked = 0;
	spc_ctrl i_dut (.clk, .rstn, .op_valid, .op, .sector, .op_ready,
		.res_valid, .res_protected, .res_data, .dq_in, .dq_out, .dq_oe_n,
		.addr, .ce_n, .oe_n, .we_n, .hv_addr_en, .hv_oe_en);
	spc_flash_model i_flash (.ce_n, .oe_n, .we_n, .hv_addr(hv_addr_en),
		.hv_oe(hv_oe_en), .addr, .host_q(dq_out), .host_oe_n(dq_oe_n),
		.bus(dq_in));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input string what, input logic [7:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic print_verdict;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict
	// Busy cycles keep a protect of sector 9 offered while busy
	task automatic run(input logic [1:0] o, input logic [5:0] s, int busy);
		int n;
		@(negedge clk);
		check("op_ready idle", {7'h0, op_ready}, 8'h01);
		op_valid = 1'b1;
		op = o;
		sector = s;
		@(negedge clk);
		check("op_ready busy", {7'h0, op_ready}, 8'h00);
		op = spc_pkg::SPC_OP_PROTECT;
		sector = 6'h09;
		repeat (busy) @(negedge clk);
		op_valid = 1'b0;
		for (n = 0; n < 3000 && res_valid !== 1'b1; n++) @(negedge clk);
		check("res_valid", {7'h0, res_valid}, 8'h01);
	endtask : run
	task automatic t_protect;
		run(spc_pkg::SPC_OP_PROTECT, 6'h05, 0);
		check("protect", {7'h0, res_protected}, 8'h01);
		run(spc_pkg::SPC_OP_VERIFY, 6'h05, 0);
		check("verify hit", res_data, 8'h01);
		run(spc_pkg::SPC_OP_VERIFY, 6'h06, 0);
		check("verify miss", res_data, 8'h00);
	endtask : t_protect
	task automatic t_query;
		run(spc_pkg::SPC_OP_QUERY, 6'h05, 0);
		check("query hit", res_data, 8'h01);
		run(spc_pkg::SPC_OP_QUERY, 6'h06, 0);
		check("query miss", res_data, 8'h00);
	endtask : t_query
	task automatic t_unprotect;
		run(spc_pkg::SPC_OP_PROTECT, 6'h3f, 0);
		run(spc_pkg::SPC_OP_UNPROTECT, 6'h00, 0);
		check("unprotect", {7'h0, res_protected}, 8'h00);
		run(spc_pkg::SPC_OP_VERIFY, 6'h05, 0);
		check("cleared", res_data, 8'h00);
	endtask : t_unprotect
	task automatic t_refuse;
		run(spc_pkg::SPC_OP_QUERY, 6'h3f, 20);
		check("busy query", res_data, 8'h00);
		run(spc_pkg::SPC_OP_VERIFY, 6'h09, 0);
		check("refused", res_data, 8'h00);
	endtask : t_refuse
	initial begin
		rstn = 1'b0;
		op_valid = 1'b0;
		op = 2'h0;
		sector = 6'h00;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		t_protect();
		t_query();
		t_unprotect();
		t_refuse();
		print_verdict();
	end
	initial begin
		#100us;
		errors++;
		print_verdict();
	end
endmodule : tb

// [verilog/spc_ctrl.sv]
/*
 * Host-side sector protection controller: protects, verifies, chip
 * unprotects and queries sectors of an external parallel flash.
 * Assumes elevated-voltage switches are driven by hv_*_en outputs.
 */
module spc_ctrl (
	input wire logic clk,
	input wire logic rstn,
	input wire logic op_valid,
	input wire logic [1:0] op,
	input wire logic [5:0] sector,
	output logic op_ready,
	output logic res_valid,
	output logic res_protected,
	output logic [7:0] res_data,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out,
	output logic dq_oe_n,
	output logic [17:0] addr,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic hv_addr_en,
	output logic hv_oe_en
);
	typedef enum logic [2:0] {
		SPC_IDLE = 3'b000,
		SPC_ISSUE = 3'b001,
		SPC_WAIT = 3'b010,
		SPC_DONE = 3'b011
	} spc_st_t;
	spc_st_t st;
	spc_pin_if pin ();
	logic [7:0] dq_meta;
	logic [7:0] dq_sync;
	spc_pkg::spc_op_t cur_op;
	logic [5:0] cur_sector;
	logic [2:0] step;
	logic [2:0] last_step;
	logic [17:0] sec_base;
	logic [5:0] sweep;
	logic sweep_more;

	////////////////////////////////////////////////////////////////////////
	// Data pins come from outside the clock domain
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dq_meta <= 8'h00;
			dq_sync <= 8'h00;
		end else begin
			dq_meta <= dq_in;
			dq_sync <= dq_meta;
		end
	end

	spc_pin_drv u_drv (
		.clk(clk),
		.rstn(rstn),
		.bus(pin.drv),
		.dq_sync(dq_sync),
		.ce_n(ce_n),
		.oe_n(oe_n),
		.we_n(we_n),
		.hv_addr_en(hv_addr_en),
		.hv_oe_en(hv_oe_en),
		.addr(addr),
		.dq_out(dq_out),
		.dq_oe_n(dq_oe_n)
	);

	assign op_ready = (st == SPC_IDLE);
	assign sec_base = {cur_sector, 12'h000};
	// unprotect first walks every sector through a protect pulse
	assign sweep_more = (cur_op == spc_pkg::SPC_OP_UNPROTECT)
		&& (step == 3'h0) && (sweep != 6'h3f);

	// Protect and unprotect end with a verify read of the latch;
	// query needs unlock, unlock, id command, read, reset
	always_comb begin
		unique case (cur_op)
			spc_pkg::SPC_OP_PROTECT: last_step = 3'h1;
			spc_pkg::SPC_OP_VERIFY: last_step = 3'h0;
			spc_pkg::SPC_OP_UNPROTECT: last_step = 3'h2;
			spc_pkg::SPC_OP_QUERY: last_step = 3'h4;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// sector counter of the sweep
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sweep <= 6'h00;
		end else if (st == SPC_IDLE) begin
			sweep <= 6'h00;
		end else if (st == SPC_WAIT && pin.done && sweep_more) begin
			sweep <= sweep + 6'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= SPC_IDLE;
			cur_op <= spc_pkg::SPC_OP_PROTECT;
			cur_sector <= 6'h00;
			step <= 3'h0;
		end else begin
			unique case (st)
				SPC_IDLE: if (op_valid) begin
					cur_op <= spc_pkg::spc_op_t'(op);
					cur_sector <= sector;
					step <= 3'h0;
					st <= SPC_ISSUE;
				end
				SPC_ISSUE: st <= SPC_WAIT;
				SPC_WAIT: if (pin.done) begin
					if (sweep_more) begin
						st <= SPC_ISSUE;
					end else if (step == last_step) begin
						st <= SPC_DONE;
					end else begin
						step <= step + 3'h1;
						st <= SPC_ISSUE;
					end
				end
				SPC_DONE: st <= SPC_IDLE;
				default: st <= SPC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cycle description handed to the pin driver
	always_comb begin
		pin.start = (st == SPC_ISSUE);
		pin.write = 1'b1;
		pin.hv_addr = 1'b0;
		pin.hv_oe = 1'b0;
		pin.addr = sec_base;
		pin.wdata = 8'h00;
		unique case (cur_op)
			spc_pkg::SPC_OP_PROTECT: begin
				pin.hv_addr = 1'b1;
				if (step == 3'h0) begin
					// elevated address pin and output enable
					pin.hv_oe = 1'b1;
				end else begin
					pin.write = 1'b0;
					pin.addr[spc_pkg::ID_PAGE_BIT] = 1'b1;
					pin.addr[spc_pkg::ID_LOW_BIT] = 1'b0;
					pin.addr[spc_pkg::MODE_SEL_BIT] = 1'b0;
				end
			end
			spc_pkg::SPC_OP_VERIFY: begin
				pin.write = 1'b0;
				pin.hv_addr = 1'b1;
				pin.addr[spc_pkg::ID_PAGE_BIT] = 1'b1;
				pin.addr[spc_pkg::ID_LOW_BIT] = 1'b0;
				pin.addr[spc_pkg::MODE_SEL_BIT] = 1'b0;
			end
			spc_pkg::SPC_OP_UNPROTECT: begin
				pin.hv_addr = 1'b1;
				if (step == 3'h0) begin
					pin.hv_oe = 1'b1;
					pin.addr = {sweep, 12'h000};
				end else if (step == 3'h1) begin
					pin.hv_oe = 1'b1;
					pin.addr[spc_pkg::MODE_SEL_BIT] = 1'b1;
				end else begin
					pin.write = 1'b0;
					pin.addr[spc_pkg::ID_PAGE_BIT] = 1'b1;
					pin.addr[spc_pkg::ID_LOW_BIT] = 1'b0;
					pin.addr[spc_pkg::MODE_SEL_BIT] = 1'b0;
				end
			end
			spc_pkg::SPC_OP_QUERY: begin
				unique case (step)
					3'h0: begin
						pin.addr = spc_pkg::ADDR_UNLOCK1;
						pin.wdata = spc_pkg::CMD_UNLOCK1;
					end
					3'h1: begin
						pin.addr = spc_pkg::ADDR_UNLOCK2;
						pin.wdata = spc_pkg::CMD_UNLOCK2;
					end
					3'h2: begin
						pin.addr = spc_pkg::ADDR_UNLOCK1;
						pin.wdata = spc_pkg::CMD_ID_READ;
					end
					3'h3: begin
						// page bit high avoids id codes
						pin.write = 1'b0;
						pin.addr[spc_pkg::ID_PAGE_BIT] = 1'b1;
						pin.addr[spc_pkg::ID_LOW_BIT] = 1'b0;
					end
					default: pin.wdata = spc_pkg::CMD_RESET;
				endcase
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			res_valid <= 1'b0;
			res_protected <= 1'b0;
			res_data <= 8'h00;
		end else begin
			res_valid <= 1'b0;
			if (st == SPC_WAIT && pin.done && !pin.write) begin
				res_data <= pin.rdata;
				res_protected <= pin.rdata[0];
			end
			if (st == SPC_DONE) begin
				res_valid <= 1'b1;
			end
		end
	end
endmodule : spc_ctrl

// [verilog/spc_pin_drv.sv]
/*
 * Runs one read or write cycle on the flash pins with fixed setup, pulse
 * and access times. Assumes data inputs are already synchronised.
 */
module spc_pin_drv (
	input wire logic clk,
	input wire logic rstn,
	spc_pin_if.drv bus,
	input wire logic [7:0] dq_sync,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic hv_addr_en,
	output logic hv_oe_en,
	output logic [17:0] addr,
	output logic [7:0] dq_out,
	output logic dq_oe_n
);
	typedef enum logic [1:0] {
		SPC_D_IDLE = 2'b00,
		SPC_D_SETUP = 2'b01,
		SPC_D_PULSE = 2'b10,
		SPC_D_HOLD = 2'b11
	} spc_drv_st_t;
	spc_drv_st_t st;
	logic [7:0] cnt;
	logic wr;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= SPC_D_IDLE;
			cnt <= 8'h00;
			wr <= 1'b0;
			bus.done <= 1'b0;
		end else begin
			bus.done <= 1'b0;
			unique case (st)
				SPC_D_IDLE: if (bus.start) begin
					wr <= bus.write;
					cnt <= 8'(spc_pkg::SETUP_CYC);
					st <= SPC_D_SETUP;
				end
				SPC_D_SETUP: if (cnt == 8'h00) begin
					cnt <= wr ? 8'(spc_pkg::WPP_CYC) : 8'(spc_pkg::ACC_CYC + 2);
					st <= SPC_D_PULSE;
				end else begin
					cnt <= cnt - 8'h01;
				end
				SPC_D_PULSE: if (cnt == 8'h00) begin
					cnt <= 8'(spc_pkg::SETUP_CYC);
					st <= SPC_D_HOLD;
				end else begin
					cnt <= cnt - 8'h01;
				end
				SPC_D_HOLD: if (cnt == 8'h00) begin
					bus.done <= 1'b1;
					st <= SPC_D_IDLE;
				end else begin
					cnt <= cnt - 8'h01;
				end
			endcase
		end
	end

	// Read data captured at the end of the access window
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus.rdata <= 8'h00;
		end else if (st == SPC_D_PULSE && cnt == 8'h00 && !wr) begin
			bus.rdata <= dq_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			hv_addr_en <= 1'b0;
			hv_oe_en <= 1'b0;
			addr <= '0;
			dq_out <= 8'h00;
			dq_oe_n <= 1'b1;
		end else if (st == SPC_D_IDLE) begin
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			dq_oe_n <= 1'b1;
			hv_addr_en <= 1'b0;
			hv_oe_en <= 1'b0;
			if (bus.start) begin
				hv_addr_en <= bus.hv_addr;
				hv_oe_en <= bus.hv_oe;
				addr <= bus.addr;
				dq_out <= bus.wdata;
				dq_oe_n <= !bus.write;
				ce_n <= 1'b0;
			end
		end else begin
			ce_n <= 1'b0;
			// output enable low, write high on reads
			oe_n <= wr || st == SPC_D_HOLD;
			we_n <= !(wr && st == SPC_D_SETUP && cnt == 8'h00)
				&& !(wr && st == SPC_D_PULSE && cnt != 8'h00);
		end
	end
endmodule : spc_pin_drv

// [verilog/spc_pin_if.sv]
/*
 * Carrier for one flash bus cycle between the sequencer and the pin driver.
 * Assumes both ends share the controller clock.
 */
interface spc_pin_if;
	logic start;
	logic write;
	logic hv_addr;
	logic hv_oe;
	logic [17:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic done;
	modport seq (output start, write, hv_addr, hv_oe, addr, wdata,
		input rdata, done);
	modport drv (input start, write, hv_addr, hv_oe, addr, wdata,
		output rdata, done);
endinterface : spc_pin_if

// [verilog/spc_pkg.sv]
/*
 * Constants for the host-side sector protection controller: pin levels,
 * command codes and timing counts in 10 ns clock cycles.
 * Assumes a 100 MHz clock and a flash device driven by parallel pins.
 */
// How it works
// - Host holds elevated select on address pin and output enable, pulses write.
// - Verify: elevated address pin, chip select and output enable low, write high.
// - Unprotect: elevated output enable and address pin, select low, mode bit high.
// - Protect every sector before running chip unprotect.
package spc_pkg;
	localparam int CLK_NS = 10;
	localparam int SETUP_NS = 70;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPP_NS = 100;
	localparam int WPP_CYC = (WPP_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_NS = 90;
	localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int SLEEP_EXTRA_NS = 30;
	localparam int SLEEP_CYC = (ACC_NS + SLEEP_EXTRA_NS + CLK_NS - 1) / CLK_NS;
	localparam int TOGGLE_NS = 2000;
	localparam int TOGGLE_CYC = TOGGLE_NS / CLK_NS;
	localparam int ADDR_W = 18;
	localparam int ID_PAGE_BIT = 1;
	localparam int ID_LOW_BIT = 0;
	localparam int MODE_SEL_BIT = 6;
	localparam int SECTOR_LSB = 12;
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_ID_READ = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 18'h00555;
	localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 18'h002aa;
	typedef enum logic [1:0] {
		SPC_OP_PROTECT = 2'b00,
		SPC_OP_VERIFY = 2'b01,
		SPC_OP_UNPROTECT = 2'b10,
		SPC_OP_QUERY = 2'b11
	} spc_op_t;
endpackage : spc_pkg
